// ==== inc/timer_array_defines.svh ====
// constants of the four-channel timer array
// assumes inclusion by package and design files alike
`ifndef TIMER_ARRAY_DEFINES_SVH
`define TIMER_ARRAY_DEFINES_SVH
`define NUM_CHANNELS 4
`define CNT_WIDTH 16
`define HALF_WIDTH 8
`define PRESCALE_BITS 15
`define COUNT_RESET 16'hFFFF
`define COUNT_CLEAR 16'h0000
`define CH_DIVIDER_A 0
`define CH_SERIAL 1
`define CH_TWO_INPUT_OUT 3
`endif

// ==== inc/timer_array_pkg.sv ====
// types shared by the timer array files
// assumes the defines header is on the include path
`include "timer_array_defines.svh"
package timer_array_pkg;
   typedef enum logic [3:0] {
      MODE_INTERVAL = 4'h0,
      MODE_SQUARE = 4'h1,
      MODE_EVENT = 4'h2,
      MODE_DIVIDER = 4'h3,
      MODE_PERIOD = 4'h4,
      MODE_WIDTH = 4'h5,
      MODE_DELAY = 4'h6,
      MODE_ONESHOT = 4'h7,
      MODE_TWO_INPUT = 4'h8,
      MODE_PWM = 4'h9
   } mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_WAIT = 2'b10
   } chan_state_t;

   typedef struct packed {
      mode_t mode;
      logic master;
      logic split;
      logic [3:0] clk_sel;
      logic [3:0] clk_sel_hi;
      logic rising;
      logic falling;
      logic out_idle;
      logic [15:0] data;
   } chan_cfg_t;

   typedef struct packed {
      logic [15:0] capture;
      logic capture_valid;
      logic [15:0] count;
      logic running;
   } chan_stat_t;
endpackage : timer_array_pkg

// ==== sim/pulse_source.sv ====
// pulse source standing in for the pins' far side
// assumes half of two clocks or more; line rests low when off
`timescale 1ns/100ps
module pulse_source (
   // clock
   input wire logic sys_clk,
   // control
   input wire logic en,
   input wire logic [7:0] half,
   // pin
   output logic pulse
);
   logic [7:0] cnt_reg = 8'h00;
   initial pulse = 1'b0;
   always @(posedge sys_clk) begin
      if (!en) begin
         cnt_reg <= 8'h00;
         pulse <= 1'b0;
      end else if (cnt_reg + 8'h01 >= half) begin
         cnt_reg <= 8'h00;
         pulse <= ~pulse;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : pulse_source

// ==== sim/timer_array_checker.sv ====
// timing checks on the timer array ports
// assumes bind onto timer_array, single clock domain
`timescale 1ns/100ps
module timer_array_checker
   import timer_array_pkg::*;
#(
   parameter int NCH = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // control
   input wire logic unit_clock_supply_enable,
   input wire logic [3:0] operating_clock_a,
   input wire timer_array_pkg::chan_cfg_t [NCH-1:0] cfg,
   input wire logic [NCH-1:0] stop,
   // pins and events
   input wire logic [NCH-1:0] chan_input_pin,
   input wire logic [NCH-1:0] chan_output_pin,
   input wire logic [NCH-1:0] chan_output_pin_oe_n,
   input wire logic [NCH-1:0] channel_irq,
   input wire logic ch1_upper_half_irq,
   input wire logic ch3_upper_half_irq,
   input wire timer_array_pkg::chan_stat_t [NCH-1:0] stat
);
   logic [23:0] gap_reg;
   logic seen_reg;
   logic [3:0] age_reg;
   // gap only trusted between two irqs of one unbroken run
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_reg <= 24'h000000;
         seen_reg <= 1'b0;
         age_reg <= 4'hF;
      end else begin
         gap_reg <= channel_irq[0] ? 24'h000001 : gap_reg + 24'h000001;
         seen_reg <= (seen_reg | channel_irq[0]) & ~stop[0] & unit_clock_supply_enable;
         age_reg <= $changed(chan_input_pin[2]) ? 4'h0 :
            (age_reg == 4'hF ? age_reg : age_reg + 4'h1);
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_sq_irq;
      channel_irq[2] && cfg[2].mode == MODE_SQUARE;
   endsequence
   property p_sq_toggle;
      s_sq_irq |-> ##[0:1] $changed(chan_output_pin[2]);
   endproperty
   a_sq_toggle: assert property (p_sq_toggle) else $error("square output missed a toggle");
   sequence s_iv_irq;
      channel_irq[0] && seen_reg && cfg[0].mode == MODE_INTERVAL && !cfg[0].clk_sel[0];
   endsequence
   property p_iv_gap;
      s_iv_irq |-> gap_reg == (24'(cfg[0].data) + 24'h000001) << operating_clock_a;
   endproperty
   a_iv_gap: assert property (p_iv_gap) else $error("interval gap wrong");
   property p_ev_pulse;
      channel_irq[1] && cfg[1].mode == MODE_EVENT |=> !channel_irq[1];
   endproperty
   a_ev_pulse: assert property (p_ev_pulse) else $error("event irq too long");
   property p_unit_off;
      !unit_clock_supply_enable |-> ##1 stat[0].count == 16'hFFFF && !stat[3].running;
   endproperty
   a_unit_off: assert property (p_unit_off) else $error("unit off kept counting");
   property p_pin_dir;
      cfg[1].mode == MODE_EVENT && $past(cfg[1].mode) == MODE_EVENT |-> chan_output_pin_oe_n[1];
   endproperty
   a_pin_dir: assert property (p_pin_dir) else $error("input pin driven");
   property p_up1;
      ch1_upper_half_irq |-> cfg[1].split;
   endproperty
   a_up1: assert property (p_up1) else $error("ch1 upper irq unsplit");
   property p_up3;
      ch3_upper_half_irq |-> cfg[3].split;
   endproperty
   a_up3: assert property (p_up3) else $error("ch3 upper irq unsplit");
   property p_cap_edge;
      $changed(stat[2].capture) && cfg[2].mode == MODE_PERIOD |-> age_reg <= 4'h6;
   endproperty
   a_cap_edge: assert property (p_cap_edge) else $error("capture without edge");
endmodule : timer_array_checker

bind timer_array timer_array_checker #(.NCH(NCH)) u_timer_array_checker (
   .sys_clk, .arst_n, .unit_clock_supply_enable, .operating_clock_a, .cfg, .stop,
   .chan_input_pin, .chan_output_pin, .chan_output_pin_oe_n, .channel_irq,
   .ch1_upper_half_irq, .ch3_upper_half_irq, .stat
);

// ==== sim/timer_array_tb_top.sv ====
// self-checking bench for the four-channel timer array
// assumes checker bound in and pulse source on the pins
`timescale 1ns/100ps
module timer_array_tb_top;
   import timer_array_pkg::*;
   logic sys_clk;
   logic arst_n;
   logic unit_clock_supply_enable;
   logic input_switch_control;
   logic [3:0] operating_clock_a;
   chan_cfg_t [3:0] cfg;
   logic [3:0] start;
   logic [3:0] stop;
   logic [3:0] pin_mask;
   logic [3:0] chan_input_pin;
   logic serial_rx_line;
   logic [3:0] chan_output_pin;
   logic [3:0] chan_output_pin_oe_n;
   logic [3:0] channel_irq;
   logic ch1_upper_half_irq;
   logic ch3_upper_half_irq;
   chan_stat_t [3:0] stat;
   logic pen;
   logic [7:0] half;
   logic pulse;
   logic v;
   int miscompares = 0;
   int comparisons = 0;
   int seed = 24204;
   int n;
   int d;
   int k;
   int e;
   // unselected pins rest low, as with a pull-down
   assign chan_input_pin = pin_mask & {4{pulse}};
   assign serial_rx_line = input_switch_control & pulse;
   timer_array u_timer_array (
      .sys_clk, .arst_n, .unit_clock_supply_enable, .input_switch_control,
      .operating_clock_a, .operating_clock_b(4'h0), .cfg, .start, .stop, .chan_input_pin,
      .serial_rx_line, .chan_output_pin, .chan_output_pin_oe_n, .channel_irq,
      .ch1_upper_half_irq, .ch3_upper_half_irq, .stat
   );
   pulse_source u_pulse_source (.sys_clk, .en(pen), .half, .pulse);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic int rnd(int lo, int span);
      return lo + int'($unsigned($random(seed)) % span);
   endfunction : rnd
   function automatic logic pick(int w);
      case (w)
         0: return channel_irq[0];
         1: return channel_irq[3];
         2: return ch3_upper_half_irq;
         4: return pulse;
         default: return channel_irq[2];
      endcase
   endfunction : pick
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : check
   task automatic wait_hi(input int w, output int cyc);
      cyc = 0;
      do begin
         @(posedge sys_clk);
         #1;
         cyc++;
      end while (pick(w) !== 1'b1 && cyc < 5000);
      if (cyc >= 5000) begin
         check(1'b0, "wait ran out");
         end_of_test();
      end
   endtask : wait_hi
   task automatic setup(input int c, input mode_t m, input logic [15:0] dv, input logic sp);
      @(posedge sys_clk);
      cfg[c] <= '{mode: m, split: sp, rising: 1'b1, data: dv, default: '0};
   endtask : setup
   // start and stop are one-cycle pulses
   task automatic ctl(input int c, input bit go);
      @(posedge sys_clk);
      start[c] <= go;
      stop[c] <= !go;
      @(posedge sys_clk);
      start <= 4'h0;
      stop <= 4'h0;
   endtask : ctl
   initial begin
      arst_n = 1'b0;
      unit_clock_supply_enable = 1'b0;
      input_switch_control = 1'b0;
      operating_clock_a = 4'h0;
      cfg = '0;
      start = 4'h0;
      stop = 4'h0;
      pin_mask = 4'h0;
      pen = 1'b0;
      half = 8'h06;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      unit_clock_supply_enable <= 1'b1;
      d = rnd(2, 8);
      k = rnd(0, 3);
      operating_clock_a <= 4'(k);
      setup(0, MODE_INTERVAL, 16'(d), 1'b0);
      ctl(0, 1'b1);
      wait_hi(0, n);
      wait_hi(0, n);
      check(n == ((d + 1) << k), "interval period");
      ctl(0, 1'b0);
      operating_clock_a <= 4'h0;
      d = rnd(2, 8);
      setup(2, MODE_SQUARE, 16'(d), 1'b0);
      ctl(2, 1'b1);
      wait_hi(3, n);
      @(posedge sys_clk);
      #1;
      v = chan_output_pin[2];
      wait_hi(3, n);
      check(n == d, "square half period");
      @(posedge sys_clk);
      #1;
      check(chan_output_pin[2] === ~v, "square toggle");
      ctl(2, 1'b0);
      // irq comes on the edge that finds the count at zero
      d = rnd(1, 4);
      setup(1, MODE_EVENT, 16'(d), 1'b0);
      pin_mask <= 4'b0010;
      ctl(1, 1'b1);
      pen <= 1'b1;
      e = 0;
      n = 0;
      v = 1'b0;
      while (channel_irq[1] !== 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         #1;
         if (pulse && !v) e++;
         v = pulse;
         n++;
      end
      check(n < 2000 && e == d + 1, "event count");
      if (n >= 2000) end_of_test();
      check(chan_output_pin_oe_n[1] === 1'b1, "pin direction");
      pen <= 1'b0;
      ctl(1, 1'b0);
      // second pass measures the serial line through channel 1, third a high width
      for (int i = 0; i < 3; i++) begin
         k = (i == 1) ? 1 : 2;
         e = (i == 2) ? 1 : 2;
         d = rnd(4, 4);
         half <= 8'(d);
         setup(k, (i == 2) ? MODE_WIDTH : MODE_PERIOD, 16'h0000, 1'b0);
         pin_mask <= (i == 1) ? 4'h0 : 4'h4;
         input_switch_control <= (i == 1);
         ctl(k, 1'b1);
         pen <= 1'b1;
         repeat (8 * d) @(posedge sys_clk);
         #1;
         check(stat[k].capture_valid, "capture flag");
         check(stat[k].capture >= 16'(e * d - 1) && stat[k].capture <= 16'(e * d + 1),
            "capture period");
         pen <= 1'b0;
         ctl(k, 1'b0);
      end
      // delay: d + 1 ticks after the edge, which lands three cycles behind the pin
      d = rnd(2, 8);
      half <= 8'h06;
      setup(2, MODE_DELAY, 16'(d), 1'b0);
      ctl(2, 1'b1);
      pen <= 1'b1;
      wait_hi(4, n);
      wait_hi(3, n);
      check(n == d + 4, "delay length");
      pen <= 1'b0;
      ctl(2, 1'b0);
      // divider: one input edge per 4 clocks, output toggles every d + 1 edges
      d = rnd(1, 3);
      half <= 8'h02;
      setup(3, MODE_DIVIDER, 16'(d), 1'b0);
      pin_mask <= 4'h8;
      ctl(3, 1'b1);
      pen <= 1'b1;
      wait_hi(1, n);
      v = chan_output_pin[3];
      wait_hi(1, n);
      check(n == 4 * (d + 1), "divider period");
      check(chan_output_pin[3] === ~v, "divider toggle");
      pen <= 1'b0;
      ctl(3, 1'b0);
      // pwm: master channel 0 sets the period, slave channel 2 the duty
      d = rnd(6, 8);
      e = rnd(1, 4);
      setup(2, MODE_PWM, 16'(e), 1'b0);
      setup(0, MODE_PWM, 16'(d), 1'b0);
      cfg[0].master <= 1'b1;
      ctl(2, 1'b1);
      ctl(0, 1'b1);
      wait_hi(0, n);
      wait_hi(0, n);
      check(n == d + 1, "pwm period");
      k = 0;
      repeat (d + 1) begin
         @(posedge sys_clk);
         #1;
         if (chan_output_pin[2] === 1'b1) k++;
      end
      check(k == e + 1, "pwm duty");
      ctl(0, 1'b0);
      ctl(2, 1'b0);
      // two-input one-shot: channel 0 edge sets, channel 3 edge clears output 3
      half <= 8'h06;
      setup(0, MODE_TWO_INPUT, 16'h0000, 1'b0);
      pin_mask <= 4'h1;
      pen <= 1'b1;
      wait_hi(4, n);
      repeat (3) @(posedge sys_clk);
      #1;
      check(chan_output_pin[3] === 1'b1, "two-input set");
      pin_mask <= 4'h8;
      repeat (3) @(posedge sys_clk);
      #1;
      check(chan_output_pin[3] === 1'b0, "two-input clear");
      pen <= 1'b0;
      d = rnd(2, 8);
      e = rnd(2, 8);
      // channel 1 split as well, so its upper half interrupt is exercised
      setup(1, MODE_INTERVAL, {8'(e), 8'(d)}, 1'b1);
      ctl(1, 1'b1);
      setup(3, MODE_INTERVAL, {8'(d), 8'(e)}, 1'b1);
      ctl(3, 1'b1);
      wait_hi(2, n);
      wait_hi(2, n);
      check(n == d + 1, "upper half period");
      wait_hi(1, n);
      wait_hi(1, n);
      check(n == e + 1, "lower half period");
      unit_clock_supply_enable <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      check(stat[3].count === 16'hFFFF && stat[3].running === 1'b0, "unit off");
      end_of_test();
   end
endmodule : timer_array_tb_top

// ==== src/timer_array.sv ====
// four-channel timer array with shared prescaler
// assumes pins arrive asynchronous; configuration is static plain ports
`timescale 1ns/100ps
`include "timer_array_defines.svh"
module timer_array #(
   parameter int NCH = `NUM_CHANNELS
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // unit control
   input wire logic unit_clock_supply_enable,
   input wire logic input_switch_control,
   input wire logic [3:0] operating_clock_a,
   input wire logic [3:0] operating_clock_b,
   // per-channel control
   input wire timer_array_pkg::chan_cfg_t [NCH-1:0] cfg,
   input wire logic [NCH-1:0] start,
   input wire logic [NCH-1:0] stop,
   // pins
   input wire logic [NCH-1:0] chan_input_pin,
   input wire logic serial_rx_line,
   output logic [NCH-1:0] chan_output_pin,
   output logic [NCH-1:0] chan_output_pin_oe_n,
   // events and status
   output logic [NCH-1:0] channel_irq,
   output logic ch1_upper_half_irq,
   output logic ch3_upper_half_irq,
   output timer_array_pkg::chan_stat_t [NCH-1:0] stat
);
   import timer_array_pkg::*;

   typedef struct packed {
      logic [14:0] pre;
      logic [NCH-1:0] sync1;
      logic [NCH-1:0] sync2;
      logic rx1;
      logic rx2;
      logic two_in_out;
      logic [NCH-1:0] prev2;
   } top_state_t;

   top_state_t t_reg;
   top_state_t t_next;
   logic [15:0] pre_ticks;
   logic [NCH-1:0] pin_sel;
   logic [NCH-1:0] out_lvl;
   logic [NCH-1:0] irq_raw;
   logic [NCH-1:0] irq_hi;
   logic [NCH-1:0] start_g;
   logic [NCH-1:0] stop_g;
   logic [15:0] ck_a_ticks;
   logic [15:0] ck_b_ticks;

   always_comb begin
      t_next = t_reg;
      t_next.sync1 = chan_input_pin;
      t_next.sync2 = t_reg.sync1;
      t_next.rx1 = serial_rx_line;
      t_next.rx2 = t_reg.rx1;
      t_next.prev2 = pin_sel;
      t_next.pre = unit_clock_supply_enable ? t_reg.pre + 15'h0001 : 15'h0000;
      if (cfg[`CH_DIVIDER_A].mode == MODE_TWO_INPUT) begin
         // channel 0 input sets, channel 3 input clears the shared output
         if (pin_sel[`CH_TWO_INPUT_OUT] && !t_reg.prev2[`CH_TWO_INPUT_OUT]) begin
            t_next.two_in_out = 1'b0;
         end else if (pin_sel[0] && !t_reg.prev2[0]) begin
            t_next.two_in_out = 1'b1;
         end
      end else begin
         t_next.two_in_out = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         t_reg <= '0;
      end else begin
         t_reg <= t_next;
      end
   end

   // tick k pulses once per 2^k clocks; bit 0 is the undivided clock
   genvar k;
   assign pre_ticks[0] = unit_clock_supply_enable;
   generate
      for (k = 1; k < 16; k++) begin : g_pre
         assign pre_ticks[k] = unit_clock_supply_enable &&
            (t_reg.pre[k-1:0] == {k{1'b1}});
      end
   endgenerate
   assign ck_a_ticks = {16{pre_ticks[operating_clock_a]}};
   assign ck_b_ticks = {16{pre_ticks[operating_clock_b]}};

   genvar n;
   generate
      for (n = 0; n < NCH; n++) begin : g_ch
         chan_cfg_t c;
         logic in_out_pin;
         if (n == `CH_SERIAL) begin : g_rx
            assign pin_sel[n] = input_switch_control ? t_reg.rx2 : t_reg.sync2[n];
         end else begin : g_pin
            assign pin_sel[n] = t_reg.sync2[n];
         end
         always_comb begin
            c = cfg[n];
            // clock select bit 0 clear picks operating clock a, set picks b; ticks index resolves
            c.clk_sel = cfg[n].clk_sel[0] ? 4'h1 : 4'h0;
            c.clk_sel_hi = cfg[n].clk_sel_hi[0] ? 4'h1 : 4'h0;
            if (cfg[n].mode == MODE_DIVIDER && n != 0 && n != 3) begin
               c.mode = MODE_INTERVAL;
            end
         end
         assign start_g[n] = start[n] && unit_clock_supply_enable;
         assign stop_g[n] = stop[n] || !unit_clock_supply_enable;
         timer_channel #(
            .CAN_SPLIT(n == 1 || n == 3)
         ) u_ch (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .cfg(c),
            .start(start_g[n]),
            .stop(stop_g[n]),
            .ticks({14'h0000, ck_b_ticks[0], ck_a_ticks[0]}),
            .pin_in(pin_sel[n]),
            .master_start(start_g[0] || (irq_raw[0] && cfg[0].master)),
            .master_irq(irq_raw[0] && cfg[0].master),
            .out_level(out_lvl[n]),
            .channel_irq(irq_raw[n]),
            .upper_half_irq(irq_hi[n]),
            .stat(stat[n])
         );
         // channel 1 pin is shared: input-type modes release the driver
         assign in_out_pin = n == 1 && (cfg[n].mode == MODE_EVENT ||
            cfg[n].mode == MODE_PERIOD || cfg[n].mode == MODE_WIDTH ||
            cfg[n].mode == MODE_DELAY || cfg[n].mode == MODE_DIVIDER);
         assign chan_output_pin_oe_n[n] = in_out_pin;
         if (n == 3) begin : g_out3
            assign chan_output_pin[n] = (cfg[0].mode == MODE_TWO_INPUT) ?
               t_reg.two_in_out : out_lvl[n];
         end else begin : g_out
            assign chan_output_pin[n] = out_lvl[n];
         end
      end
   endgenerate

   assign channel_irq = irq_raw;
   assign ch1_upper_half_irq = irq_hi[1];
   assign ch3_upper_half_irq = irq_hi[3];
endmodule : timer_array

// ==== src/timer_channel.sv ====
// one 16-bit timer channel, splittable into two 8-bit halves
// assumes synchronised pin input and prescaler tick vector from the top
`timescale 1ns/100ps
`include "timer_array_defines.svh"
module timer_channel #(
   parameter bit CAN_SPLIT = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // configuration and control
   input wire timer_array_pkg::chan_cfg_t cfg,
   input wire logic start,
   input wire logic stop,
   input wire logic [15:0] ticks,
   // pin and master links
   input wire logic pin_in,
   input wire logic master_start,
   input wire logic master_irq,
   // results
   output logic out_level,
   output logic channel_irq,
   output logic upper_half_irq,
   output timer_array_pkg::chan_stat_t stat
);
   import timer_array_pkg::*;

   typedef struct packed {
      chan_state_t st;
      logic [15:0] cnt;
      logic [15:0] cap;
      logic cap_v;
      logic pin_d;
      logic out;
      logic irq;
      logic irq_hi;
   } ch_state_t;

   ch_state_t s_reg;
   ch_state_t s_next;
   logic split_on;
   logic tick;
   logic tick_hi;
   logic edge_seen;
   logic slave_mode;
   logic count_up;

   function automatic logic valid_edge(input logic prev, input logic now,
                                       input logic r, input logic f);
      valid_edge = (r && !prev && now) || (f && prev && !now);
   endfunction : valid_edge

   assign split_on = CAN_SPLIT && cfg.split;
   assign tick = ticks[cfg.clk_sel];
   assign tick_hi = ticks[cfg.clk_sel_hi];
   assign edge_seen = valid_edge(s_reg.pin_d, pin_in, cfg.rising, cfg.falling);
   assign slave_mode = !cfg.master &&
      (cfg.mode == MODE_ONESHOT || cfg.mode == MODE_PWM);
   assign count_up = cfg.mode == MODE_PERIOD || cfg.mode == MODE_WIDTH;

   always_comb begin
      s_next = s_reg;
      s_next.pin_d = pin_in;
      s_next.irq = 1'b0;
      s_next.irq_hi = 1'b0;
      if (stop) begin
         s_next.st = ST_IDLE;
         s_next.cnt = `COUNT_RESET;
         s_next.out = cfg.out_idle;
      end else begin
         case (s_reg.st)
            ST_IDLE: begin
               if (start) begin
                  s_next.cap_v = 1'b0;
                  s_next.out = cfg.out_idle;
                  if (count_up) begin
                     s_next.cnt = `COUNT_CLEAR;
                     s_next.st = ST_WAIT;
                  end else if (cfg.mode == MODE_DELAY || slave_mode) begin
                     s_next.cnt = cfg.data;
                     s_next.st = ST_WAIT;
                  end else begin
                     s_next.cnt = cfg.data;
                     s_next.st = ST_RUN;
                  end
               end
            end
            ST_WAIT: begin
               // input edge or master event arms the count; two-input mode arms at once
               if (cfg.mode == MODE_TWO_INPUT) begin
                  s_next.st = ST_RUN;
               end else if (slave_mode) begin
                  if (master_start) begin
                     s_next.cnt = cfg.data;
                     s_next.st = ST_RUN;
                     if (cfg.mode == MODE_PWM) begin
                        s_next.out = !cfg.out_idle;
                     end
                  end
               end else if (edge_seen) begin
                  s_next.st = ST_RUN;
                  s_next.cnt = count_up ? `COUNT_CLEAR : cfg.data;
               end
            end
            ST_RUN: begin
               if (count_up) begin
                  if (edge_seen || (cfg.mode == MODE_WIDTH &&
                      valid_edge(s_reg.pin_d, pin_in, cfg.falling, cfg.rising))) begin
                     // width mode captures on the opposite edge only
                     if (cfg.mode == MODE_PERIOD || !edge_seen) begin
                        s_next.cap = s_reg.cnt;
                        s_next.cap_v = 1'b1;
                        s_next.irq = 1'b1;
                        s_next.cnt = `COUNT_CLEAR;
                        s_next.st = cfg.mode == MODE_WIDTH ? ST_WAIT : ST_RUN;
                     end
                  end else if (tick) begin
                     s_next.cnt = s_reg.cnt + 16'h0001;
                  end
               end else begin
                  if (slave_mode && master_irq && cfg.mode == MODE_PWM) begin
                     s_next.cnt = cfg.data;
                     s_next.out = !cfg.out_idle;
                  end
                  if (cfg.mode == MODE_EVENT || cfg.mode == MODE_DIVIDER) begin
                     if (edge_seen) begin
                        s_next.cnt = s_reg.cnt - 16'h0001;
                     end
                  end else if (tick) begin
                     s_next.cnt = s_reg.cnt - 16'h0001;
                  end
                  if (split_on) begin
                     s_next.cnt[15:8] = s_reg.cnt[15:8];
                     if (tick_hi) begin
                        s_next.cnt[15:8] = s_reg.cnt[15:8] - 8'h01;
                     end
                     if (tick_hi && s_reg.cnt[15:8] == 8'h00) begin
                        s_next.cnt[15:8] = cfg.data[15:8];
                        s_next.irq_hi = 1'b1;
                     end
                  end
                  if ((split_on ? s_reg.cnt[7:0] == 8'h00 : s_reg.cnt == 16'h0000) &&
                      ((cfg.mode == MODE_EVENT || cfg.mode == MODE_DIVIDER) ?
                       edge_seen : tick)) begin
                     s_next.irq = 1'b1;
                     if (split_on) begin
                        s_next.cnt[7:0] = cfg.data[7:0];
                     end else begin
                        s_next.cnt = cfg.data;
                     end
                     case (cfg.mode)
                        MODE_SQUARE, MODE_DIVIDER: s_next.out = !s_reg.out;
                        MODE_DELAY: begin
                           s_next.cnt = `COUNT_RESET;
                           s_next.st = ST_WAIT;
                        end
                        MODE_ONESHOT: begin
                           s_next.out = cfg.master ? s_reg.out : !s_reg.out;
                           s_next.cnt = `COUNT_RESET;
                           s_next.st = ST_WAIT;
                        end
                        MODE_PWM: begin
                           if (!cfg.master) begin
                              s_next.out = cfg.out_idle;
                              s_next.cnt = `COUNT_RESET;
                              s_next.st = ST_WAIT;
                           end
                        end
                        default: s_next.out = s_reg.out;
                     endcase
                  end
               end
            end
            default: s_next.st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '{st: ST_IDLE, cnt: `COUNT_RESET, cap: `COUNT_CLEAR, default: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign out_level = s_reg.out;
   assign channel_irq = s_reg.irq;
   assign upper_half_irq = s_reg.irq_hi;
   assign stat = '{capture: s_reg.cap, capture_valid: s_reg.cap_v,
                   count: s_reg.cnt, running: s_reg.st != ST_IDLE};
endmodule : timer_channel
